/* cttm_consts.vh */
`ifndef CTTM_CONSTS_VH
`define CTTM_CONSTS_VH

// Register write values that steer test mode
`define CTTM_TEST_CTRL_ENABLE   8'h0f
`define CTTM_UNLOCK_FIRST       8'h54
`define CTTM_UNLOCK_SECOND      8'h46
`define CTTM_UNLOCK_DISABLE     8'h00

// State command field values
`define CTTM_CMD_TX_START       8'h02
`define CTTM_CMD_RADIO_OFF      8'h03
`define CTTM_CMD_PLL_ON         8'h09

// State readback codes
`define CTTM_STATUS_RADIO_OFF   8'h08
`define CTTM_STATUS_PLL_ON      8'h09
`define CTTM_STATUS_BUSY_TX     8'h02

// Carrier wave payload bytes
`define CTTM_CW_BYTE_LOW        8'h00
`define CTTM_CW_BYTE_HIGH       8'hff

// Frame buffer layout
`define CTTM_FB_DEPTH           128
`define CTTM_FB_LEN_ADDR        7'h00
`define CTTM_FB_FIRST_PSDU      7'h01
`define CTTM_LEN_ZERO           7'h00

// Reset values
`define CTTM_BYTE_RESET         8'h00

`endif

/* cttm_unlock.v */
`timescale 1ns/100ps
`default_nettype none
`include "cttm_consts.vh"

module cttm_unlock (
  input  wire       clock_in,
  input  wire       reset_in,
  input  wire       radio_off_in,
  input  wire       test_ctrl_write_in,
  input  wire [7:0] test_ctrl_data_in,
  input  wire       part_number_unlock_reg_write_in,
  input  wire [7:0] part_number_unlock_reg_data_in,
  output reg        test_active_out,
  output reg        test_ended_out
);

  // ==========================================================
  // Unlock sequence states
  localparam [4:0] ST_IDLE   = 5'b00001;
  localparam [4:0] ST_ARMED  = 5'b00010;
  localparam [4:0] ST_STEP2  = 5'b00100;
  localparam [4:0] ST_ACTIVE = 5'b01000;
  localparam [4:0] ST_ENDED  = 5'b10000;

  reg [4:0] state_reg;
  reg [4:0] state_next;

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (test_ctrl_write_in && radio_off_in &&
            test_ctrl_data_in == `CTTM_TEST_CTRL_ENABLE) begin
          state_next = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (test_ctrl_write_in &&
            test_ctrl_data_in != `CTTM_TEST_CTRL_ENABLE) begin
          state_next = ST_IDLE;
        end else if (part_number_unlock_reg_write_in) begin
          if (part_number_unlock_reg_data_in == `CTTM_UNLOCK_FIRST) begin
            state_next = ST_STEP2;
          end else begin
            state_next = ST_IDLE;
          end
        end
      end
      ST_STEP2: begin
        if (part_number_unlock_reg_write_in) begin
          if (part_number_unlock_reg_data_in == `CTTM_UNLOCK_SECOND) begin
            state_next = ST_ACTIVE;
          end else begin
            state_next = ST_IDLE;
          end
        end else if (test_ctrl_write_in) begin
          state_next = ST_IDLE;
        end
      end
      ST_ACTIVE: begin
        if (part_number_unlock_reg_write_in &&
            part_number_unlock_reg_data_in == `CTTM_UNLOCK_DISABLE) begin
          state_next = ST_ENDED;
        end
      end
      ST_ENDED: begin
        state_next = ST_ENDED;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clock_in) begin
    if (reset_in) begin
      state_reg       <= ST_IDLE;
      test_active_out <= 1'b0;
      test_ended_out  <= 1'b0;
    end else begin
      state_reg       <= state_next;
      test_active_out <= (state_next == ST_ACTIVE);
      test_ended_out  <= (state_next == ST_ENDED);
    end
  end

endmodule // cttm_unlock

`default_nettype wire

/* cttm_continuous_tx.v */
`timescale 1ns/100ps
`default_nettype none
`include "cttm_consts.vh"

module cttm_continuous_tx (
  input  wire       clock_in,
  input  wire       reset_in,
  input  wire       carrier_mode_sel_in,
  input  wire       test_ctrl_write_in,
  input  wire [7:0] test_ctrl_data_in,
  input  wire       part_number_unlock_reg_write_in,
  input  wire [7:0] part_number_unlock_reg_data_in,
  input  wire       state_cmd_write_in,
  input  wire [7:0] state_cmd_data_in,
  input  wire       fb_write_in,
  input  wire [6:0] fb_addr_in,
  input  wire [7:0] fb_data_in,
  input  wire       pll_lock_in,
  input  wire       tx_ready_in,
  output reg        test_active_out,
  output reg        test_ended_out,
  output reg  [7:0] state_readback_out,
  output reg        pll_lock_irq_out,
  output reg        tx_valid_out,
  output reg  [7:0] tx_byte_out,
  output reg        cw_enable_out,
  output reg        cw_tone_high_out,
  output reg        cw_pattern_error_out
);

  // ==========================================================
  // Radio states
  localparam [2:0] RS_OFF  = 3'b001;
  localparam [2:0] RS_PLL  = 3'b010;
  localparam [2:0] RS_BUSY = 3'b100;

  reg  [2:0] radio_reg;
  reg  [2:0] radio_next;
  reg        lock_sync1_reg;
  reg        lock_sync2_reg;
  reg        lock_prev_reg;
  reg        locked_reg;
  reg  [7:0] fb_mem [0:`CTTM_FB_DEPTH-1];
  reg  [6:0] index_reg;
  reg  [6:0] index_next;
  wire       unlock_active;
  wire       unlock_ended;
  wire [6:0] frame_len;
  wire [7:0] cur_byte;
  wire       streaming;
  wire       advance;
  wire       lock_rise;

  // ==========================================================
  // Unlock sequence
  cttm_unlock u_unlock (
    .clock_in           (clock_in),
    .reset_in           (reset_in),
    .radio_off_in       (radio_reg == RS_OFF),
    .test_ctrl_write_in (test_ctrl_write_in),
    .test_ctrl_data_in  (test_ctrl_data_in),
    .part_number_unlock_reg_write_in  (part_number_unlock_reg_write_in),
    .part_number_unlock_reg_data_in   (part_number_unlock_reg_data_in),
    .test_active_out    (unlock_active),
    .test_ended_out     (unlock_ended)
  );

  // ==========================================================
  // Synthesizer lock synchroniser
  always @(posedge clock_in) begin
    if (reset_in) begin
      lock_sync1_reg <= 1'b0;
      lock_sync2_reg <= 1'b0;
      lock_prev_reg  <= 1'b0;
    end else begin
      lock_sync1_reg <= pll_lock_in;
      lock_sync2_reg <= lock_sync1_reg;
      lock_prev_reg  <= lock_sync2_reg;
    end
  end

  assign lock_rise = lock_sync2_reg && !lock_prev_reg;

  // ==========================================================
  // Radio state command handling
  always @* begin
    radio_next = radio_reg;
    case (radio_reg)
      RS_OFF: begin
        if (state_cmd_write_in &&
            state_cmd_data_in == `CTTM_CMD_PLL_ON) begin
          radio_next = RS_PLL;
        end
      end
      RS_PLL: begin
        if (state_cmd_write_in) begin
          if (state_cmd_data_in == `CTTM_CMD_RADIO_OFF) begin
            radio_next = RS_OFF;
          end else if (state_cmd_data_in == `CTTM_CMD_TX_START &&
                       locked_reg) begin
            radio_next = RS_BUSY;
          end
        end
      end
      RS_BUSY: begin
        if (state_cmd_write_in &&
            state_cmd_data_in == `CTTM_CMD_RADIO_OFF) begin
          radio_next = RS_OFF;
        end else if (!unlock_active) begin
          radio_next = RS_PLL;
        end
      end
      default: begin
        radio_next = RS_OFF;
      end
    endcase
  end

  always @(posedge clock_in) begin
    if (reset_in) begin
      radio_reg          <= RS_OFF;
      locked_reg         <= 1'b0;
      pll_lock_irq_out   <= 1'b0;
      state_readback_out <= `CTTM_STATUS_RADIO_OFF;
    end else begin
      radio_reg        <= radio_next;
      pll_lock_irq_out <= lock_rise && (radio_reg == RS_PLL);
      if (radio_next == RS_OFF) begin
        locked_reg <= 1'b0;
      end else if (lock_rise) begin
        locked_reg <= 1'b1;
      end
      case (radio_next)
        RS_PLL:  state_readback_out <= `CTTM_STATUS_PLL_ON;
        RS_BUSY: state_readback_out <= `CTTM_STATUS_BUSY_TX;
        default: state_readback_out <= `CTTM_STATUS_RADIO_OFF;
      endcase
    end
  end

  // ==========================================================
  // Frame buffer
  always @(posedge clock_in) begin
    if (fb_write_in) begin
      fb_mem[fb_addr_in] <= fb_data_in;
    end
  end

  // Length byte holds 7 bits; zero length means no valid header
  assign frame_len = fb_mem[`CTTM_FB_LEN_ADDR][6:0];
  assign cur_byte  = fb_mem[index_reg];
  assign streaming = unlock_active && (radio_reg == RS_BUSY) &&
                     (frame_len != `CTTM_LEN_ZERO);
  // Index moves exactly when a pattern byte is loaded, or every cycle in carrier mode, so none repeats
  assign advance   = streaming &&
                     (carrier_mode_sel_in || !tx_valid_out || tx_ready_in);

  // ==========================================================
  // Payload walker: PSDU bytes only, wrapping without a gap
  always @* begin
    index_next = index_reg;
    if (!streaming) begin
      index_next = `CTTM_FB_FIRST_PSDU;
    end else if (advance) begin
      if (index_reg >= frame_len) begin
        index_next = `CTTM_FB_FIRST_PSDU;
      end else begin
        index_next = index_reg + 7'h01;
      end
    end
  end

  always @(posedge clock_in) begin
    if (reset_in) begin
      index_reg            <= `CTTM_FB_FIRST_PSDU;
      test_active_out      <= 1'b0;
      test_ended_out       <= 1'b0;
      tx_valid_out         <= 1'b0;
      tx_byte_out          <= `CTTM_BYTE_RESET;
      cw_enable_out        <= 1'b0;
      cw_tone_high_out     <= 1'b0;
      cw_pattern_error_out <= 1'b0;
    end else begin
      index_reg       <= index_next;
      test_active_out <= unlock_active;
      test_ended_out  <= unlock_ended;
      // Pattern mode: modulated bytes held until the RF path takes them
      if (!streaming || carrier_mode_sel_in) begin
        tx_valid_out <= 1'b0;
      end else if (!tx_valid_out || tx_ready_in) begin
        tx_valid_out <= 1'b1;
        tx_byte_out  <= cur_byte;
      end
      // Carrier mode: tone side follows each 0xff or 0x00 payload byte; any other byte sets the pattern error
      cw_enable_out <= streaming && carrier_mode_sel_in;
      if (streaming && carrier_mode_sel_in) begin
        if (cur_byte == `CTTM_CW_BYTE_HIGH) begin
          cw_tone_high_out <= 1'b1;
        end else if (cur_byte == `CTTM_CW_BYTE_LOW) begin
          cw_tone_high_out <= 1'b0;
        end else begin
          cw_pattern_error_out <= 1'b1;
        end
      end else if (!streaming) begin
        cw_pattern_error_out <= 1'b0;
      end
    end
  end

endmodule // cttm_continuous_tx

`default_nettype wire

/* cttm_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module cttm_checker (
  input wire logic       clock_in,
  input wire logic       reset_in,
  input wire logic       part_number_unlock_reg_write_in,
  input wire logic [7:0] part_number_unlock_reg_data_in,
  input wire logic       state_cmd_write_in,
  input wire logic [7:0] state_cmd_data_in,
  input wire logic       tx_ready_in,
  input wire logic       test_active_out,
  input wire logic       test_ended_out,
  input wire logic [7:0] state_readback_out,
  input wire logic       pll_lock_irq_out,
  input wire logic       tx_valid_out,
  input wire logic [7:0] tx_byte_out,
  input wire logic       cw_enable_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  // ==========
  // Entry and exit
  a_unlock_cause: assert property ($rose(test_active_out) |->
    $past(part_number_unlock_reg_write_in, 2) && $past(part_number_unlock_reg_data_in, 2) == 8'h46)
    else $error("test mode on without 0x46");
  a_ended_final: assert property (test_ended_out ##1 test_ended_out
    |-> !test_active_out) else $error("active after disable");
  // ==========
  // State commands and lock
  a_pll_from_off: assert property (state_cmd_write_in &&
    state_cmd_data_in == 8'h09 && state_readback_out == 8'h08
    |-> ##2 state_readback_out == 8'h09) else $error("no pll on");
  a_busy_cause: assert property ($rose(state_readback_out == 8'h02)
    |-> $past(state_cmd_write_in) && $past(state_cmd_data_in) == 8'h02)
    else $error("busy without start");
  a_irq_pulse: assert property (pll_lock_irq_out |=>
    !pll_lock_irq_out) else $error("lock irq too long");
  a_irq_state: assert property (pll_lock_irq_out |->
    state_readback_out == 8'h09) else $error("lock irq off pll on");
  // ==========
  // Streaming
  a_tx_busy: assert property (tx_valid_out |->
    state_readback_out == 8'h02 || $past(state_readback_out) == 8'h02)
    else $error("tx outside busy");
  a_cw_busy: assert property (cw_enable_out |->
    $past(state_readback_out) == 8'h02 || $past(state_readback_out, 2) == 8'h02)
    else $error("carrier outside busy");
  a_tx_hold: assert property (tx_valid_out && !tx_ready_in &&
    test_active_out |=> !test_active_out || (tx_valid_out &&
    $stable(tx_byte_out))) else $error("byte not held");
endmodule // cttm_checker
bind cttm_continuous_tx cttm_checker i_chk (
  .clock_in(clock_in), .reset_in(reset_in),
  .part_number_unlock_reg_write_in(part_number_unlock_reg_write_in), .part_number_unlock_reg_data_in(part_number_unlock_reg_data_in),
  .state_cmd_write_in(state_cmd_write_in),
  .state_cmd_data_in(state_cmd_data_in), .tx_ready_in(tx_ready_in),
  .test_active_out(test_active_out), .test_ended_out(test_ended_out),
  .state_readback_out(state_readback_out),
  .pll_lock_irq_out(pll_lock_irq_out), .tx_valid_out(tx_valid_out),
  .tx_byte_out(tx_byte_out), .cw_enable_out(cw_enable_out));
`default_nettype wire

/* cttm_rf_model.sv */
`timescale 1ns/100ps
`default_nettype none
module cttm_rf_model #(parameter int LOCK_DELAY = 6) (
  input  wire logic       clock_in,
  input  wire logic       reset_in,
  input  wire logic [7:0] state_readback_in,
  output logic            tx_ready_out,
  output logic            pll_lock_out
);
  logic [3:0] wait_reg;
  logic [1:0] stall_reg;
  // Synthesizer locks some cycles after leaving radio off
  always @(posedge clock_in) begin
    stall_reg <= reset_in ? 2'h0 : stall_reg + 2'h1;
    if (reset_in || state_readback_in == 8'h08) begin
      wait_reg <= 4'h0;
      pll_lock_out <= 1'b0;
    end else if (wait_reg != LOCK_DELAY[3:0]) begin
      wait_reg <= wait_reg + 4'h1;
    end else begin
      pll_lock_out <= 1'b1;
    end
  end
  // RF path refuses one slot in four
  assign tx_ready_out = stall_reg != 2'h3;
endmodule // cttm_rf_model
`default_nettype wire

/* test_continuous_tx_test_mode.sv */
`timescale 1ns/100ps
`default_nettype none
module test_continuous_tx_test_mode;
  logic       clock_in, reset_in, sel;
  logic [3:0] stb;
  logic [7:0] wd;
  logic [6:0] wa;
  wire logic  rdy, lock, active, ended, irq, valid, cw_en, cw_hi, cw_err;
  wire logic [7:0] rb, tx_byte;
  int fails = 0, n_checks = 0, cycles = 0, i, k;
  logic [7:0] rows [5][4] = '{'{8'h0f, 8'h54, 8'h46, 8'h01},
    '{8'h0e, 8'h54, 8'h46, 8'h00}, '{8'h0f, 8'h46, 8'h54, 8'h00},
    '{8'h0f, 8'h54, 8'h47, 8'h00}, '{8'h0f, 8'h55, 8'h46, 8'h00}};
  logic [7:0] cw_bytes [3] = '{8'hff, 8'h00, 8'h5a};

  cttm_continuous_tx i_dut (.clock_in(clock_in), .reset_in(reset_in),
    .carrier_mode_sel_in(sel), .test_ctrl_write_in(stb[0]),
    .test_ctrl_data_in(wd), .part_number_unlock_reg_write_in(stb[1]),
    .part_number_unlock_reg_data_in(wd), .state_cmd_write_in(stb[2]),
    .state_cmd_data_in(wd), .fb_write_in(stb[3]), .fb_addr_in(wa),
    .fb_data_in(wd), .pll_lock_in(lock), .tx_ready_in(rdy),
    .test_active_out(active), .test_ended_out(ended),
    .state_readback_out(rb), .pll_lock_irq_out(irq), .tx_valid_out(valid),
    .tx_byte_out(tx_byte), .cw_enable_out(cw_en),
    .cw_tone_high_out(cw_hi), .cw_pattern_error_out(cw_err));
  cttm_rf_model #(.LOCK_DELAY(6)) i_rf (.clock_in(clock_in),
    .reset_in(reset_in), .state_readback_in(rb), .tx_ready_out(rdy),
    .pll_lock_out(lock));

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
  end
  // ==========
  // Tasks
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [1:0] kind, input logic [7:0] d,
                    input logic [6:0] a = 7'h00);
    @(posedge clock_in);
    #1;
    stb = 4'h1 << kind;
    wd = d;
    wa = a;
    @(posedge clock_in);
    #1;
    stb = 4'h0;
  endtask
  task automatic rst();
    @(posedge clock_in);
    #1;
    reset_in = 1'b1;
    repeat (16) @(posedge clock_in);
    #1;
    reset_in = 1'b0;
    wr(2'h2, 8'h03);
  endtask
  task automatic unlock(input logic [7:0] a, b, c);
    wr(2'h0, a);
    wr(2'h1, b);
    wr(2'h1, c);
    repeat (2) @(posedge clock_in);
    #1;
  endtask
  task automatic load(input logic [6:0] n, input logic [7:0] v, s);
    wr(2'h3, {1'b0, n});
    for (int j = 1; j <= n; j++) wr(2'h3, v + s * j[7:0], j[6:0]);
  endtask
  task automatic start();
    wr(2'h2, 8'h09);
    chk("pll_on", 8'h09, rb);
    wr(2'h2, 8'h02);
    chk("early_start", 8'h09, rb);
    for (k = 0; k < 100 && irq !== 1'b1; k++) @(negedge clock_in);
    chk("lock_irq", 8'h01, {7'h00, irq});
    wr(2'h2, 8'h02);
    chk("busy_tx", 8'h02, rb);
  endtask
  // ==========
  // Tests
  initial begin
    reset_in = 1'b1;
    sel = 1'b0;
    stb = 4'h0;
    wd = 8'h00;
    wa = 7'h00;
    rst();
    chk("readback", 8'h08, rb);
    chk("outputs", 8'h00, {1'b0, active, ended, irq, valid, cw_en, cw_hi,
        cw_err});
    $display("done reset");
    for (i = 0; i < 5; i++) begin
      rst();
      unlock(rows[i][0], rows[i][1], rows[i][2]);
      chk("active", rows[i][3], {7'h00, active});
    end
    $display("done unlock table");
    for (int c = 0; c < 2; c++) begin
      rst();
      sel = 1'b0;
      if (c == 0) load(7'h04, 8'ha0, 8'h01);
      else load(7'h7f, 8'h11, 8'h25);
      unlock(8'h0f, 8'h54, 8'h46);
      start();
      k = 0;
      for (i = 0; i < 200 && k < 130; i++) begin
        @(negedge clock_in);
        if (valid === 1'b1 && rdy === 1'b1) begin
          chk("tx_byte", (c == 0) ? 8'ha0 + 8'(k % 4 + 1) :
              8'h11 + 8'h25 * 8'(k % 127 + 1), tx_byte);
          k++;
        end
      end
      chk("stream_count", 8'h82, 8'(k));
    end
    $display("done pattern stream");
    for (i = 0; i < 3; i++) begin
      rst();
      sel = 1'b1;
      load(7'h03, cw_bytes[i], 8'h00);
      unlock(8'h0f, 8'h54, 8'h46);
      start();
      repeat (4) @(negedge clock_in);
      chk("cw_error", {7'h00, cw_bytes[i] == 8'h5a}, {7'h00, cw_err});
      if (cw_bytes[i] != 8'h5a) begin
        chk("cw_on", 8'h01, {7'h00, cw_en});
        chk("cw_high", {7'h00, cw_bytes[i] == 8'hff}, {7'h00, cw_hi});
      end
    end
    $display("done carrier");
    wr(2'h1, 8'h00);
    repeat (4) @(negedge clock_in);
    chk("ended", 8'h01, {7'h00, ended});
    chk("active_off", 8'h00, {7'h00, active});
    chk("busy_left", 8'h09, rb);
    unlock(8'h0f, 8'h54, 8'h46);
    chk("relock", 8'h00, {7'h00, active});
    rst();
    chk("ended_reset", 8'h00, {7'h00, ended});
    $display("done disable");
    conclude();
  end
endmodule // test_continuous_tx_test_mode
`default_nettype wire
